// File: logic/lsb_lcd_core.sv
// Segment display core: timing, blink and Wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Base clock is input over 16 shl select
// R2 - Frame spans one base tick per backplane
// R3 - Software keeps frame rate in 30-100 Hz
// R4 - Duty code sets two, three or four backplanes
// R5 - Normal or low-power waveform, one-third bias
// R6 - Bank bit picks on/off or blink bank
// R7 - Enabled segment bit one drives on level
// R8 - Memory stays usable and untouched by enable
// R9 - Memory has no reset value
// R10 - Clear zeroes only the selected bank
// R11 - Software picks bank before issuing clear; the core takes the bank bit of the clearing write itself
// R12 - Blank forces off, timing keeps running
// R13 - Blink change applies at next frame
// R14 - Blink-all ignores the blink-enable bank
// R15 - Individual blink needs on and enable bits
// R16 - Each byte holds two frontplanes' bits
// R17 - Blink divider is 32 shl rate field
// R18 - Blink off phase shows off level
// R19 - Backplanes scanned in equal slots
module lsb_lcd_core (
	// Clock and reset
	input  wire logic                           clock_i,
	input  wire logic                           reset_i,
	// LCD clock input, sampled on clock_i
	input  wire logic                           lcd_clock_i,
	// Wishbone slave
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [lsb_pkg::ADR_W-1:0]      wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [lsb_pkg::DAT_W-1:0]      wb_dat_i,
	output logic                                wb_ack_o,
	output logic      [lsb_pkg::DAT_W-1:0]      wb_dat_o,
	// Pin levels towards the drivers
	output logic [lsb_pkg::BP_N*lsb_pkg::LVL_W-1:0] backplane_level_o,
	output logic [lsb_pkg::FP_N*lsb_pkg::LVL_W-1:0] frontplane_level_o,
	output logic                                frame_start_o
);
	import lsb_pkg::*;

	// Backplanes in the scan for a duty code
	function automatic logic [2:0] bp_used(
		input logic [1:0] duty
	);
		unique case (duty)
			DUTY_HALF:  bp_used = 3'h2;
			DUTY_THIRD: bp_used = 3'h3;
			DUTY_QUART: bp_used = 3'h4;
			// Code 00 is undefined; scan all four
			default:    bp_used = 3'h4;
		endcase
	endfunction : bp_used

	function automatic logic is_mem(
		input logic [ADR_W-1:0] adr
	);
		is_mem = (adr & ADR_MEM_MSK) == ADR_MEM;
	endfunction : is_mem

	// Configuration
	logic                   en_q;
	logic                   en_d;
	logic                   lpw_q;
	logic                   lpw_d;
	logic [1:0]             duty_q;
	logic [1:0]             duty_d;
	logic [2:0]             lclk_q;
	logic [2:0]             lclk_d;
	logic                   bank_q;
	logic                   bank_d;
	logic                   blank_q;
	logic                   blank_d;
	logic                   breq_q;
	logic                   breq_d;
	logic                   ball_q;
	logic                   ball_d;
	logic [2:0]             rate_q;
	logic [2:0]             rate_d;
	logic [FP_N-1:0]        fpen_q;
	logic [FP_N-1:0]        fpen_d;
	// Bus
	logic                   ack_q;
	logic                   ack_d;
	logic [DAT_W-1:0]       rdat_q;
	logic [DAT_W-1:0]       rdat_d;
	logic                   req;
	logic                   wr;
	logic                   mem_wr;
	logic                   clr;
	logic [7:0]             mem_byte;
	logic [SEG_N-1:0]       on_bits;
	logic [SEG_N-1:0]       bl_bits;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	// R8 memory open while disabled
	assign mem_wr = wr && is_mem(wb_adr_i) && wb_sel_i[0];
	// R10 clear pulse from command
	assign clr = wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[CMD_CLR];

	always_comb begin
		en_d = en_q;
		lpw_d = lpw_q;
		duty_d = duty_q;
		lclk_d = lclk_q;
		bank_d = bank_q;
		blank_d = blank_q;
		breq_d = breq_q;
		ball_d = ball_q;
		rate_d = rate_q;
		fpen_d = fpen_q;
		if (wr && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				ADR_CTRL: begin
					en_d = wb_dat_i[CTRL_EN];
					lpw_d = wb_dat_i[CTRL_LPW];
					duty_d = wb_dat_i[CTRL_DUTY +: 2];
					lclk_d = wb_dat_i[CTRL_LCLK +: 3];
				end
				ADR_CMD: begin
					bank_d = wb_dat_i[CMD_BANK];
					blank_d = wb_dat_i[CMD_BLANK];
				end
				ADR_BLINK: begin
					breq_d = wb_dat_i[BLK_REQ];
					ball_d = wb_dat_i[BLK_ALL];
					rate_d = wb_dat_i[BLK_RATE +: 3];
				end
				default: begin
				end
			endcase
		end
		if (wr && wb_adr_i == ADR_FPEN) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					fpen_d[b*8 +: 8] = wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			en_q <= 1'b0;
			lpw_q <= 1'b0;
			duty_q <= DUTY_RST;
			lclk_q <= 3'h0;
			bank_q <= 1'b0;
			blank_q <= 1'b0;
			breq_q <= 1'b0;
			ball_q <= 1'b0;
			rate_q <= 3'h0;
			fpen_q <= FPEN_RST;
		end else begin
			en_q <= en_d;
			lpw_q <= lpw_d;
			duty_q <= duty_d;
			lclk_q <= lclk_d;
			bank_q <= bank_d;
			blank_q <= blank_d;
			breq_q <= breq_d;
			ball_q <= ball_d;
			rate_q <= rate_d;
			fpen_q <= fpen_d;
		end
	end

	// R6 memory with bank select
	lsb_seg_mem u_mem (
		.clock_i      (clock_i),
		.wr_en_i      (mem_wr),
		.wr_bank_i    (bank_q),
		.wr_idx_i     (wb_adr_i[5:2]),
		.wr_byte_i    (wb_dat_i[7:0]),
		.clr_i        (clr),
		.clr_bank_i   (wb_dat_i[CMD_BANK]),
		.rd_bank_i    (bank_q),
		.rd_idx_i     (wb_adr_i[5:2]),
		.rd_byte_o    (mem_byte),
		.on_bits_o    (on_bits),
		.blink_bits_o (bl_bits)
	);

	// Timing state
	logic                   lck_q;
	logic [DIV_W-1:0]       div_q;
	logic [DIV_W-1:0]       div_d;
	logic [1:0]             bp_q;
	logic [1:0]             bp_d;
	logic                   half_q;
	logic                   half_d;
	logic                   par_q;
	logic                   par_d;
	logic                   bact_q;
	logic                   bact_d;
	logic [BLK_W-1:0]       bcnt_q;
	logic [BLK_W-1:0]       bcnt_d;
	logic                   boff_q;
	logic                   boff_d;
	logic                   fst_q;
	logic                   fst_d;
	logic [DIV_W-1:0]       div_lim;
	logic [BLK_W-1:0]       blk_lim;
	logic [2:0]             used;
	logic                   lrise;
	logic                   base_tick;
	logic                   half_tick;
	logic                   frame_tick;

	// R1 base clock divider
	assign div_lim = BASE_DIV_MIN << lclk_q;
	// R17 blink divider
	assign blk_lim = BLINK_DIV_MIN << rate_q;
	// R4 backplanes in scan
	assign used = bp_used(duty_q);
	assign lrise = lcd_clock_i && !lck_q;
	assign base_tick = en_q && lrise && div_q == div_lim - 12'h001;
	assign half_tick = en_q && lrise && div_q == (div_lim >> 1) - 12'h001;
	// R2 one slot per used backplane
	assign frame_tick = base_tick && {1'b0, bp_q} == used - 3'h1;

	always_comb begin
		div_d = div_q;
		bp_d = bp_q;
		half_d = half_q;
		par_d = par_q;
		bact_d = bact_q;
		bcnt_d = bcnt_q;
		boff_d = boff_q;
		fst_d = frame_tick;
		// R12 timing ignores blank
		if (!en_q) begin
			div_d = '0;
			bp_d = 2'h0;
			half_d = 1'b0;
		end else if (lrise) begin
			div_d = base_tick ? '0 : div_q + 12'h001;
		end
		if (half_tick) begin
			half_d = 1'b1;
		end
		// R19 equal slots in turn
		if (base_tick) begin
			half_d = 1'b0;
			bp_d = frame_tick ? 2'h0 : bp_q + 2'h1;
		end
		if (frame_tick) begin
			par_d = !par_q;
			// R13 blink change at frame start
			bact_d = breq_q;
		end
		if (!bact_q) begin
			bcnt_d = '0;
			boff_d = 1'b0;
		end else if (base_tick) begin
			if (bcnt_q == blk_lim - 13'h0001) begin
				bcnt_d = '0;
				boff_d = !boff_q;
			end else begin
				bcnt_d = bcnt_q + 13'h0001;
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			lck_q <= 1'b0;
			div_q <= '0;
			bp_q <= 2'h0;
			half_q <= 1'b0;
			par_q <= 1'b0;
			bact_q <= 1'b0;
			bcnt_q <= '0;
			boff_q <= 1'b0;
			fst_q <= 1'b0;
		end else begin
			lck_q <= lcd_clock_i;
			div_q <= div_d;
			bp_q <= bp_d;
			half_q <= half_d;
			par_q <= par_d;
			bact_q <= bact_d;
			bcnt_q <= bcnt_d;
			boff_q <= boff_d;
			fst_q <= fst_d;
		end
	end

	// R5 polarity: per half slot or per frame
	logic pol;
	assign pol = lpw_q ? par_q : half_q;

	logic [BP_N*LVL_W-1:0] bpl_d;
	logic [BP_N*LVL_W-1:0] bpl_q;
	logic [FP_N*LVL_W-1:0] fpl_d;
	logic [FP_N*LVL_W-1:0] fpl_q;

	generate
		for (genvar k = 0; k < BP_N; k++) begin : g_bp
			logic act;
			assign act = bp_q == 2'(k) && 3'(k) < used;
			assign bpl_d[k*LVL_W +: LVL_W] = !en_q ? LVL_0 :
				act ? (pol ? LVL_3 : LVL_0) : (pol ? LVL_1 : LVL_2);
		end
		for (genvar n = 0; n < FP_N; n++) begin : g_fp
			logic on_bit;
			logic bl_bit;
			logic hide;
			logic seg;
			// R16 nibble per frontplane
			assign on_bit = on_bits[n*BP_N + int'(bp_q)];
			assign bl_bit = bl_bits[n*BP_N + int'(bp_q)];
			// R14 R15 R18 blink off phase
			assign hide = bact_q && boff_q && (ball_q || bl_bit);
			// R7 R12 on level only when shown
			assign seg = on_bit && fpen_q[n] && !blank_q && !hide;
			assign fpl_d[n*LVL_W +: LVL_W] = !en_q ? LVL_0 :
				seg ? (pol ? LVL_0 : LVL_3) : (pol ? LVL_2 : LVL_1);
		end
	endgenerate

	always_comb begin
		ack_d = req;
		rdat_d = '0;
		if (req && !wb_we_i) begin
			if (is_mem(wb_adr_i)) begin
				rdat_d[7:0] = mem_byte;
			end else begin
				unique case (wb_adr_i)
					ADR_CTRL: begin
						rdat_d[CTRL_EN] = en_q;
						rdat_d[CTRL_LPW] = lpw_q;
						rdat_d[CTRL_DUTY +: 2] = duty_q;
						rdat_d[CTRL_LCLK +: 3] = lclk_q;
					end
					ADR_CMD: begin
						rdat_d[CMD_BANK] = bank_q;
						rdat_d[CMD_BLANK] = blank_q;
					end
					ADR_BLINK: begin
						rdat_d[BLK_REQ] = breq_q;
						rdat_d[BLK_ALL] = ball_q;
						rdat_d[BLK_RATE +: 3] = rate_q;
					end
					ADR_FPEN: rdat_d = fpen_q;
					ADR_STAT: rdat_d[5:0] = {boff_q, bact_q, par_q, half_q, bp_q};
					default: rdat_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			ack_q <= 1'b0;
			rdat_q <= '0;
			bpl_q <= '0;
			fpl_q <= '0;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			bpl_q <= bpl_d;
			fpl_q <= fpl_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign backplane_level_o = bpl_q;
	assign frontplane_level_o = fpl_q;
	assign frame_start_o = fst_q;
endmodule : lsb_lcd_core
`default_nettype wire

// File: logic/lsb_pkg.sv
// Constants and register map of the segment display core
package lsb_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int FP_N = 32;
	localparam int BP_N = 4;
	localparam int MEM_N = 16;
	localparam int SEG_N = 128;
	localparam int DIV_W = 12;
	localparam int BLK_W = 13;
	localparam int LVL_W = 2;
	// Register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD = 8'h04;
	localparam logic [7:0] ADR_BLINK = 8'h08;
	localparam logic [7:0] ADR_FPEN = 8'h0C;
	localparam logic [7:0] ADR_STAT = 8'h10;
	localparam logic [7:0] ADR_MEM = 8'h40;
	localparam logic [7:0] ADR_MEM_MSK = 8'hC3;
	// Control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_LPW = 1;
	localparam int CTRL_DUTY = 2;
	localparam int CTRL_LCLK = 4;
	// Command register fields
	localparam int CMD_BANK = 0;
	localparam int CMD_BLANK = 1;
	localparam int CMD_CLR = 2;
	// Blink control fields
	localparam int BLK_REQ = 0;
	localparam int BLK_ALL = 1;
	localparam int BLK_RATE = 2;
	// Reset values
	localparam logic [1:0] DUTY_RST = 2'h3;
	localparam logic [31:0] FPEN_RST = 32'h0000_0000;
	// Duty codes
	localparam logic [1:0] DUTY_HALF = 2'h1;
	localparam logic [1:0] DUTY_THIRD = 2'h2;
	localparam logic [1:0] DUTY_QUART = 2'h3;
	// Divider bases
	localparam logic [DIV_W-1:0] BASE_DIV_MIN = 12'h010;
	localparam logic [BLK_W-1:0] BLINK_DIV_MIN = 13'h0020;
	// Pin levels for one-third bias, as fractions of the top rail
	localparam logic [1:0] LVL_0 = 2'h0;
	localparam logic [1:0] LVL_1 = 2'h1;
	localparam logic [1:0] LVL_2 = 2'h2;
	localparam logic [1:0] LVL_3 = 2'h3;
endpackage : lsb_pkg

// File: logic/lsb_seg_mem.sv
// Segment memory: on/off bank and blink-enable bank
`timescale 1ns/1ps
`default_nettype none
module lsb_seg_mem (
	// Clock
	input  wire logic                        clock_i,
	// Byte write port
	input  wire logic                        wr_en_i,
	input  wire logic                        wr_bank_i,
	input  wire logic [3:0]                  wr_idx_i,
	input  wire logic [7:0]                  wr_byte_i,
	// Clear of one bank
	input  wire logic                        clr_i,
	input  wire logic                        clr_bank_i,
	// Byte read port
	input  wire logic                        rd_bank_i,
	input  wire logic [3:0]                  rd_idx_i,
	output logic      [7:0]                  rd_byte_o,
	// Whole banks for the display scan
	output logic      [lsb_pkg::SEG_N-1:0]   on_bits_o,
	output logic      [lsb_pkg::SEG_N-1:0]   blink_bits_o
);
	import lsb_pkg::*;

	logic [7:0] on_q [MEM_N];
	logic [7:0] on_d [MEM_N];
	logic [7:0] bl_q [MEM_N];
	logic [7:0] bl_d [MEM_N];

	// R9 no reset
	always_comb begin
		for (int i = 0; i < MEM_N; i++) begin
			on_d[i] = on_q[i];
			bl_d[i] = bl_q[i];
			// R10 clear selected bank
			if (clr_i && !clr_bank_i) begin
				on_d[i] = 8'h00;
			end
			if (clr_i && clr_bank_i) begin
				bl_d[i] = 8'h00;
			end
			// R6 bank routing
			if (wr_en_i && wr_idx_i == 4'(i)) begin
				if (wr_bank_i) begin
					bl_d[i] = wr_byte_i;
				end else begin
					on_d[i] = wr_byte_i;
				end
			end
		end
	end

	// Contents are held without reset so they survive any reset
	always_ff @(posedge clock_i) begin
		on_q <= on_d;
		bl_q <= bl_d;
	end

	assign rd_byte_o = rd_bank_i ? bl_q[rd_idx_i] : on_q[rd_idx_i];

	// R16 two frontplanes per byte
	generate
		for (genvar g = 0; g < MEM_N; g++) begin : g_flat
			assign on_bits_o[g*8 +: 8] = on_q[g];
			assign blink_bits_o[g*8 +: 8] = bl_q[g];
		end
	endgenerate
endmodule : lsb_seg_mem
`default_nettype wire

// File: verif/lsb_glass.sv
// Glass model: which segments of two frontplanes lit during the last frame
`timescale 1ns/1ps
`default_nettype none
module lsb_glass (
	input  wire logic       clock_i,
	input  wire logic [7:0] bp_i,
	input  wire logic [3:0] fp_i,
	input  wire logic       frame_i,
	output logic      [7:0] seg_o
);
	logic [7:0] lit_q, lit_d, seg_d, cur;
	always_comb begin
		cur = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if ({fp_i[2*(i/4)+:2], bp_i[2*(i%4)+:2]} inside {4'h3, 4'hC})
				cur[i] = 1'b1;
		end
		// Levels lag the frame pulse by one cycle, so the pulse cycle closes the old frame
		seg_d = frame_i ? (lit_q | cur) : seg_o;
		lit_d = frame_i ? 8'h00 : (lit_q | cur);
	end
	always_ff @(posedge clock_i) begin
		lit_q <= lit_d;
		seg_o <= seg_d;
	end
endmodule : lsb_glass
`default_nettype wire

// File: verif/lsb_lcd_core_properties.sv
// Bus and scan timing checks of the segment display core
`timescale 1ns/1ps
`default_nettype none
module lsb_lcd_core_properties (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        reset_i,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Scan
	input wire logic [7:0]  backplane_level_o,
	input wire logic        frame_start_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_resp;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_mem_upper;
		wb_ack_o && !wb_we_i && wb_adr_i[7:6] == 2'h1 |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_mem_upper: assert property (p_mem_upper) else $error("memory read upper bits");
	property p_cmd_clr;
		wb_ack_o && !wb_we_i && wb_adr_i == lsb_pkg::ADR_CMD |-> wb_dat_o[31:2] == 30'h0;
	endproperty
	a_cmd_clr: assert property (p_cmd_clr) else $error("clear bit reads back");
	property p_unmapped;
		wb_ack_o && !wb_we_i && (wb_adr_i[7] || wb_adr_i[7:5] == 3'h1) |-> wb_dat_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_fs_pulse;
		frame_start_o |=> (!frame_start_o)[*8];
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("frame starts too close");
	property p_bp_hold;
		$changed(backplane_level_o) && !$past(wb_ack_o) |=>
			($stable(backplane_level_o) || wb_ack_o || $past(wb_ack_o))[*8];
	endproperty
	a_bp_hold: assert property (p_bp_hold) else $error("backplane slot too short");
	property p_fs_live;
		frame_start_o && !wb_ack_o && !$past(wb_ack_o) |-> backplane_level_o != 8'h00;
	endproperty
	a_fs_live: assert property (p_fs_live) else $error("frame while outputs idle");
	c_frame: cover property (frame_start_o);
	c_read: cover property (wb_ack_o && !wb_we_i);
	c_scan: cover property ($changed(backplane_level_o));
endmodule : lsb_lcd_core_properties
bind lsb_lcd_core lsb_lcd_core_properties lsb_lcd_core_properties_inst (.clock_i, .reset_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_dat_o, .backplane_level_o,
	.frame_start_o);
`default_nettype wire

// File: verif/lsb_lcd_core_test.sv
// Self-checking bench of the segment display core
`timescale 1ns/1ps
`default_nettype none
module lsb_lcd_core_test;
	import lsb_pkg::*;
	logic        clock_i, reset_i, lcd_clock_i, cyc, stb, we, ack, fs;
	logic [7:0]  adr, seg, bp;
	logic [3:0]  sel;
	logic [31:0] dat, rdat, q;
	logic [63:0] fp;
	logic [7:0]  mem [2][16];
	int          miscompares, checks, cycles, t, n;
	lsb_lcd_core lsb_lcd_core_inst (.clock_i, .reset_i, .lcd_clock_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_ack_o(ack), .wb_dat_o(rdat), .backplane_level_o(bp), .frontplane_level_o(fp),
		.frame_start_o(fs));
	lsb_glass lsb_glass_inst (.clock_i, .bp_i(bp), .fp_i(fp[3:0]), .frame_i(fs), .seg_o(seg));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		lcd_clock_i <= reset_i ? 1'b0 : ~lcd_clock_i;
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		checks++;
		if (v !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		{cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
		do @(posedge clock_i); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'h0;
	endtask : wb
	task automatic frames(input int k);
		repeat (k) do @(posedge clock_i); while (fs !== 1'b1);
		#1;
	endtask : frames
	task automatic readback();
		for (int b = 0; b < 2; b++) begin
			wb(1'b1, ADR_CMD, 32'(b));
			for (int i = 0; i < 16; i++) begin
				wb(1'b0, ADR_MEM + 8'(4 * i), 32'h0);
				chk("mem", q, {24'h0, mem[b][i]});
			end
		end
		$display("readback finished");
	endtask : readback
	function automatic logic [7:0] shown(input logic [7:0] on, input logic [1:0] d);
		shown = on & {2{d == DUTY_HALF ? 4'h3 : d == DUTY_THIRD ? 4'h7 : 4'hF}};
	endfunction : shown
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		{reset_i, cyc, stb, we, adr, dat, sel} = {2'h2, 2'h0, 8'h00, 32'h0, 4'hF};
		void'($urandom(82028));
		repeat (12) @(posedge clock_i);
		reset_i <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk("ctrl", q, {28'h0, DUTY_RST, 2'h0});
		for (int i = 1; i < 5; i++) begin
			wb(1'b0, 8'(4 * i), 32'h0);
			chk("reg", q, 32'h0);
		end
		wb(1'b1, 8'h24, 32'hFFFF_FFFF);
		wb(1'b0, 8'h24, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("registers finished");
		// No reset value is assumed: every byte is written first
		for (int b = 0; b < 2; b++) begin
			wb(1'b1, ADR_CMD, 32'(b));
			for (int i = 0; i < 16; i++) begin
				mem[b][i] = 8'($urandom);
				wb(1'b1, ADR_MEM + 8'(4 * i), {24'h0, mem[b][i]});
			end
		end
		wb(1'b1, ADR_CTRL, 32'h0000_000D);
		// bank picked in the clearing write
		wb(1'b1, ADR_CMD, 32'h0000_0005);
		mem[1] = '{default: 8'h00};
		readback();
		wb(1'b1, ADR_FPEN, 32'h0000_0003);
		wb(1'b0, ADR_FPEN, 32'h0);
		chk("fpen", q, 32'h0000_0003);
		wb(1'b1, ADR_CMD, 32'h0);
		for (int m = 2; m < 8; m++) begin
			mem[0][0] = 8'($urandom);
			wb(1'b1, ADR_MEM, {24'h0, mem[0][0]});
			// shortest divider keeps the run brief
			wb(1'b1, ADR_CTRL, 32'(m * 2 + 1));
			frames(3);
			chk("seg", 32'(seg), 32'(shown(mem[0][0], 2'(m >> 1))));
		end
		wb(1'b1, ADR_CMD, 32'h2);
		frames(3);
		chk("blank", 32'(seg), 32'h0);
		readback();
		for (int s = 0; s < 3; s++) begin
			wb(1'b1, ADR_CTRL, 32'({s[2:0], 4'hD}));
			frames(2);
			t = cycles;
			frames(1);
			chk("frame", cycles - t, 128 << s);
		end
		wb(1'b1, ADR_CTRL, 32'h0000_000D);
		mem[1][0] = 8'($urandom) | 8'h01;
		wb(1'b1, ADR_MEM, {24'h0, mem[1][0]});
		wb(1'b1, ADR_CMD, 32'h0);
		mem[0][0] = 8'hFF;
		wb(1'b1, ADR_MEM, 32'h0000_00FF);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, ADR_BLINK, 32'({k[1], k[0], 1'b1}));
			frames(1);
			n = 0;
			for (int f = 0; f < (16 << k[1]); f++) begin
				frames(1);
				n += int'(seg === (k[0] ? 8'h00 : mem[0][0] & ~mem[1][0]));
			end
			chk("dark", n, 8 << k[1]);
			wb(1'b1, ADR_BLINK, 32'h0);
			frames(2);
		end
		$display("blink finished");
		end_of_test();
	end
endmodule : lsb_lcd_core_test
`default_nettype wire
